/* File: core/voltage_comparator_unit.sv */
// top of the comparator event control block: ahb-lite slave, event logic,
// pin and timer routing, low-power handling
// assumes one clock hclk, a system that reports its power mode, and an
// analog comparator whose raw output arrives asynchronously
// and a bus whose hready is this slave's own hreadyout
//
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
module voltage_comparator_unit
   import cmp_event_pkg::*;
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // power mode and debug state
   input  wire power_mode_t power_mode,
   input  wire logic        debug_halt,
   // analog comparator side
   input  wire logic        raw_compare_out,
   output logic             analog_enable,
   output logic             bandgap_select,
   output logic             bandgap_buffer_enable,
   // pins and timer
   output logic             compare_out_pin,
   output logic             compare_out_pin_oe,
   input  wire logic        first_timer_chan0_pin_in,
   output logic             first_timer_chan0_pin_oe_allow,
   output logic             first_timer_capture_in,
   // interrupt and wake
   output logic             compare_irq,
   output logic             wake_request
);
   // control state
   logic       comparator_enable_bit_r;
   logic       reference_input_select_r;
   logic       compare_event_flag_r;
   logic       compare_irq_enable_r;
   logic       compare_out_pin_enable_r;
   logic [1:0] event_edge_select_r;
   logic       compare_to_timer_route_r;
   logic       bandgap_buffer_enable_r;
   logic       out_pin_r;

   // bus data phase state
   logic        wr_pend_r;
   logic [11:0] addr_r;
   logic [31:0] rdata_r;

   // synchroniser flush counter after enabling
   logic [1:0]  settle_cnt_r;

   // internal nets
   logic        deep_stop;
   logic        running;
   logic        sync_level;
   logic        event_pulse;
   logic        compare_result_bit;
   logic        addr_phase;
   logic        flag_clear;
   logic        wr_status;
   logic        wr_options;
   logic        wr_power;
   logic [31:0] rd_word;
   logic [11:0] rd_addr;
   logic        detect_active;
   logic        low_power;

   // synchroniser depth; the edge detector waits this many edges after enabling
   localparam int unsigned sync_stages = 2;
   localparam logic [1:0]  settle_done = 2'(sync_stages);

   // deep stop removes power; holding state in reset models the loss of settings
   // options and power words sit outside the block and keep their values
   assign deep_stop = (power_mode == mode_deep);

   // run, wait, shallow stop and debug halt all keep an enabled comparator going;
   // debug_halt is left unused on purpose, a halted processor must not stop
   // compare events from being caught
   assign running = comparator_enable_bit_r && !deep_stop;

   // ahb address phase accepted on any selected nonseq or seq transfer, whatever its size
   assign addr_phase = hsel && hready && htrans[1];

   // zero wait state slave, always okay; every register is a flop, so no
   // access ever needs extra time
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // capture the address phase for the following data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         addr_r    <= 12'h000;
      end else begin
         wr_pend_r <= addr_phase && hwrite;
         if (addr_phase) begin
            addr_r <= haddr & addr_mask;
         end
      end
   end

   // register write decode happens in the data phase; the address is held
   // because hwdata only arrives one cycle after it
   assign wr_status  = wr_pend_r && (addr_r == status_ctrl_off);
   assign wr_options = wr_pend_r && (addr_r == sys_options_off);
   assign wr_power   = wr_pend_r && (addr_r == power_ctrl_off);
   assign flag_clear = wr_status && hwdata[flag_pos];

   // synchronise the raw comparator output
   cmp_sync #(
      .stages (sync_stages)
   ) u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .din     (raw_compare_out),
      .dout    (sync_level)
   );

   // the synchroniser still holds samples from before enabling for a few edges;
   // detection waits until they have flushed so enabling raises no stale event
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         settle_cnt_r <= 2'h0;
      end else if (!running) begin
         settle_cnt_r <= 2'h0;
      end else if (settle_cnt_r != settle_done) begin
         settle_cnt_r <= settle_cnt_r + 2'h1;
      end
   end

   // edge detection runs once the synchronised level is trustworthy
   assign detect_active = running && (settle_cnt_r == settle_done);

   // edge condition from the mode field
   cmp_edge_detect u_edge (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .active      (detect_active),
      .sel         (edge_sel_t'(event_edge_select_r)),
      .level       (sync_level),
      .event_pulse (event_pulse)
   );

   // result bit is forced low whenever the comparator is off
   assign compare_result_bit = running && sync_level;

   // comparator enable; system reset also covers leaving stop by reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         comparator_enable_bit_r <= status_ctrl_rst[enable_pos];
      end else if (deep_stop) begin
         comparator_enable_bit_r <= 1'b0;
      end else if (wr_status) begin
         comparator_enable_bit_r <= hwdata[enable_pos];
      end
   end

   // reference select: internal bandgap or external input
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reference_input_select_r <= status_ctrl_rst[ref_sel_pos];
      end else if (deep_stop) begin
         reference_input_select_r <= 1'b0;
      end else if (wr_status) begin
         reference_input_select_r <= hwdata[ref_sel_pos];
      end
   end

   // interrupt enable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         compare_irq_enable_r <= status_ctrl_rst[irq_en_pos];
      end else if (deep_stop) begin
         compare_irq_enable_r <= 1'b0;
      end else if (wr_status) begin
         compare_irq_enable_r <= hwdata[irq_en_pos];
      end
   end

   // output pin enable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         compare_out_pin_enable_r <= status_ctrl_rst[pin_en_pos];
      end else if (deep_stop) begin
         compare_out_pin_enable_r <= 1'b0;
      end else if (wr_status) begin
         compare_out_pin_enable_r <= hwdata[pin_en_pos];
      end
   end

   // event mode field, two bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         event_edge_select_r <= status_ctrl_rst[edge_hi_pos:edge_lo_pos];
      end else if (deep_stop) begin
         event_edge_select_r <= 2'h0;
      end else if (wr_status) begin
         event_edge_select_r <= hwdata[edge_hi_pos:edge_lo_pos];
      end
   end

   // sticky flag: an event in the clearing cycle wins over the clear, so an
   // edge that lands on software's own clear is never lost
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         compare_event_flag_r <= 1'b0;
      end else if (deep_stop) begin
         compare_event_flag_r <= 1'b0;
      end else if (event_pulse) begin
         compare_event_flag_r <= 1'b1;
      end else if (flag_clear) begin
         compare_event_flag_r <= 1'b0;
      end
   end

   // comparator-to-timer routing lives in the system options word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         compare_to_timer_route_r <= 1'b0;
      end else if (wr_options) begin
         compare_to_timer_route_r <= hwdata[timer_route_pos];
      end
   end

   // bandgap buffer enable lives in the power control word; software sets it
   // before choosing the bandgap, the block never forces it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bandgap_buffer_enable_r <= 1'b0;
      end else if (wr_power) begin
         bandgap_buffer_enable_r <= hwdata[bg_buf_pos];
      end
   end

   // reads decode the address phase so the data phase can come from a flop
   assign rd_addr = haddr & addr_mask;

   // read mux; bits above the fields read as zero
   always_comb begin
      rd_word = 32'h0000_0000;
      case (rd_addr)
         status_ctrl_off: begin
            rd_word[enable_pos]  = comparator_enable_bit_r;
            rd_word[ref_sel_pos] = reference_input_select_r;
            rd_word[flag_pos]    = compare_event_flag_r;
            rd_word[irq_en_pos]  = compare_irq_enable_r;
            rd_word[result_pos]  = compare_result_bit;
            rd_word[pin_en_pos]  = compare_out_pin_enable_r;
            rd_word[edge_hi_pos:edge_lo_pos] = event_edge_select_r;
         end
         sys_options_off: begin
            rd_word[timer_route_pos] = compare_to_timer_route_r;
         end
         power_ctrl_off: begin
            rd_word[bg_buf_pos] = bandgap_buffer_enable_r;
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   // read data captured at the address phase edge and driven from the flop;
   // a read issued right behind a write still sees the value before that write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_r <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         rdata_r <= rd_word;
      end
   end

   // hrdata stands for the whole read data phase
   assign hrdata = rdata_r;

   // output pin follows the result in run and shallow stop alike; the flop
   // costs a cycle of lag but keeps mux glitches off the pad
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_pin_r <= 1'b0;
      end else begin
         out_pin_r <= compare_out_pin_enable_r && compare_result_bit;
      end
   end

   assign compare_out_pin    = out_pin_r;
   assign compare_out_pin_oe = compare_out_pin_enable_r && !deep_stop;

   // timer capture source and channel-0 pin ownership; the timer sees the
   // synchronised level, so it never samples a metastable value
   assign first_timer_capture_in = compare_to_timer_route_r ? compare_result_bit
                                                            : first_timer_chan0_pin_in;
   assign first_timer_chan0_pin_oe_allow = !compare_to_timer_route_r;

   // analog controls; the reference select only steers the analog mux, the
   // buffer that feeds it stays under software control
   assign analog_enable         = running;
   assign bandgap_select        = reference_input_select_r;
   assign bandgap_buffer_enable = bandgap_buffer_enable_r;

   // interrupt level and wake request; a level, not a pulse, so the request
   // stays until software clears the flag
   assign compare_irq  = compare_irq_enable_r && compare_event_flag_r;
   // only wait and shallow stop need waking; deep stop has the block unpowered
   assign low_power    = (power_mode == mode_wait) || (power_mode == mode_shallow);
   assign wake_request = compare_irq && low_power;
endmodule

/* File: core/cmp_event_pkg.sv */
// constants shared by the comparator event control block
// assumes a 32-bit AHB-Lite register bus, one aligned word per register
package cmp_event_pkg;
   // register byte offsets
   localparam logic [11:0] status_ctrl_off   = 12'h000;
   localparam logic [11:0] sys_options_off   = 12'h004;
   localparam logic [11:0] power_ctrl_off    = 12'h008;
   localparam logic [11:0] addr_mask         = 12'hffc;
   // status and control field positions
   localparam int unsigned enable_pos        = 7;
   localparam int unsigned ref_sel_pos       = 6;
   localparam int unsigned flag_pos          = 5;
   localparam int unsigned irq_en_pos        = 4;
   localparam int unsigned result_pos        = 3;
   localparam int unsigned pin_en_pos        = 2;
   localparam int unsigned edge_hi_pos       = 1;
   localparam int unsigned edge_lo_pos       = 0;
   // system options and power control fields
   localparam int unsigned timer_route_pos   = 0;
   localparam int unsigned bg_buf_pos        = 0;
   // reset values
   localparam logic [7:0]  status_ctrl_rst   = 8'h00;
   // edge select codes
   typedef enum logic [1:0] {
      edge_fall_a = 2'b00,
      edge_rise   = 2'b01,
      edge_fall_b = 2'b10,
      edge_both   = 2'b11
   } edge_sel_t;
   // power modes seen by the block
   typedef enum logic [1:0] {
      mode_run        = 2'b00,
      mode_wait       = 2'b01,
      mode_shallow    = 2'b10,
      mode_deep       = 2'b11
   } power_mode_t;
   // ahb transfer type and transfer size codes
   localparam logic [1:0]  htrans_nonseq     = 2'b10;
   localparam logic [2:0]  hsize_word        = 3'b010;
endpackage

/* File: core/cmp_sync.sv */
// two flip-flop synchroniser for the raw comparator level
// assumes the input is asynchronous to hclk
`timescale 1ns/100ps
module cmp_sync #(
   parameter int unsigned stages = 2
) (
   // clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // level in and out
   input  wire logic din,
   output logic      dout
);
   logic [stages-1:0] chain_r;

   // first stage feeds only the second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chain_r <= '0;
      end else begin
         chain_r <= {chain_r[stages-2:0], din};
      end
   end

   assign dout = chain_r[stages-1];
endmodule

/* File: core/cmp_edge_detect.sv */
// edge detector with selectable event condition
// assumes a synchronised input level and a clear that restarts history
`timescale 1ns/100ps
module cmp_edge_detect
   import cmp_event_pkg::*;
(
   // clock and reset
   input  wire logic      hclk,
   input  wire logic      hresetn,
   // control
   input  wire logic      active,
   input  wire edge_sel_t sel,
   // level in, event out
   input  wire logic      level,
   output logic           event_pulse
);
   logic prev_r;
   logic rise;
   logic fall;

   // history follows the level only while active and is held low otherwise, so enabling while the level is high gives a rising edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= active ? level : 1'b0;
      end
   end

   assign rise = active && level && !prev_r;
   assign fall = active && !level && prev_r;

   // event condition by mode code
   always_comb begin
      case (sel)
         edge_fall_a: event_pulse = fall;
         edge_rise:   event_pulse = rise;
         edge_fall_b: event_pulse = fall;
         edge_both:   event_pulse = rise || fall;
         default:     event_pulse = 1'b0;
      endcase
   end
endmodule

/* File: tb/cmp_event_props.sv */
// port checker for the comparator event control block
// assumes it is bound to voltage_comparator_unit, one clock domain
`timescale 1ns/100ps
module cmp_event_props
   import cmp_event_pkg::*;
(
   // clock, reset and bus
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // mode, comparator, pins
   input wire power_mode_t power_mode,
   input wire logic        raw_compare_out,
   input wire logic        analog_enable,
   input wire logic        compare_out_pin,
   input wire logic        compare_out_pin_oe,
   input wire logic        first_timer_chan0_pin_in,
   input wire logic        first_timer_chan0_pin_oe_allow,
   input wire logic        first_timer_capture_in,
   input wire logic        compare_irq,
   input wire logic        wake_request
);
   logic wr_dp_r;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // a write in its data phase may legally move the flag or irq enable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         wr_dp_r <= 1'b0;
      else
         wr_dp_r <= hsel && hready && htrans[1] && hwrite;
   end
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus stall or error");
   a_wake_gate: assert property (wake_request == (compare_irq &&
      (power_mode == mode_wait || power_mode == mode_shallow))) else $error("wake wrong");
   a_capture_pin: assert property (first_timer_chan0_pin_oe_allow |->
      first_timer_capture_in == first_timer_chan0_pin_in) else $error("capture wrong");
   a_deep_off: assert property (power_mode == mode_deep |->
      !analog_enable && !compare_out_pin_oe) else $error("powered in deep stop");
   a_deep_clear: assert property ((power_mode == mode_deep)[*2] |-> !compare_irq)
      else $error("flag kept in deep stop");
   a_flag_sticky: assert property (compare_irq && !wr_dp_r && power_mode != mode_deep
      |=> compare_irq) else $error("irq dropped");
   // two sync stages: a new level reaches the flag three edges later
   a_event_sync: assert property ($rose(compare_irq) && !$past(wr_dp_r) |->
      $past(raw_compare_out, 3) != $past(raw_compare_out, 4) ||
      $past(raw_compare_out, 2) != $past(raw_compare_out, 3)) else $error("event w/o edge");
   a_pin_gated: assert property ((!compare_out_pin_oe)[*3] |-> !compare_out_pin)
      else $error("pin high while off");
   c_irq: cover property ($rose(compare_irq));
   c_wake: cover property ($rose(wake_request));
   c_route: cover property ($fell(first_timer_chan0_pin_oe_allow));
endmodule

/* File: tb/analog_side_model.sv */
// comparator front end and timer pin seen from the block
// assumes lvl is the wanted comparator result while enabled
`timescale 1ns/100ps
module analog_side_model (
   // clock and control
   input  wire logic hclk,
   input  wire logic analog_enable,
   input  wire logic lvl,
   // far side levels
   output logic      raw_compare_out,
   output logic      timer_pin
);
   logic tog = 1'b0;
   // off edge, so the synchroniser sees a truly asynchronous source
   always @(posedge hclk) begin
      #37 tog <= ~tog;
   end
   // a powered-down comparator gives garbage, never a held value
   assign raw_compare_out = analog_enable ? lvl : tog;
   assign timer_pin       = tog;
endmodule

/* File: tb/voltage_comparator_unit_tb_top.sv */
// self-checking bench for the comparator event control block
// assumes the analog side model and the port checker are compiled first
`timescale 1ns/100ps
module voltage_comparator_unit_tb_top
   import cmp_event_pkg::*;
;
   localparam logic [31:0] en_c = 32'h80, ref_c = 32'h40, flg_c = 32'h20;
   localparam logic [31:0] ie_c = 32'h10, res_c = 32'h08, pe_c = 32'h04;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, debug_halt = 1'b0;
   logic lvl = 1'b0, rise, wk;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'b00;
   logic [31:0] hwdata = 32'h0, q, ctl;
   power_mode_t power_mode = mode_run;
   wire logic [31:0] hrdata;
   wire logic hreadyout, hresp, raw, ae, bsel, bbuf, opin, ooe, tpin, oe_allow, cap, irq, wake;
   int err_count = 0, checked = 0;
   always #50 hclk = ~hclk;
   analog_side_model u_far (.hclk, .analog_enable(ae), .lvl, .raw_compare_out(raw),
      .timer_pin(tpin));
   voltage_comparator_unit u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(hsize_word), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .power_mode, .debug_halt, .raw_compare_out(raw), .analog_enable(ae),
      .bandgap_select(bsel), .bandgap_buffer_enable(bbuf), .compare_out_pin(opin),
      .compare_out_pin_oe(ooe), .first_timer_chan0_pin_in(tpin),
      .first_timer_chan0_pin_oe_allow(oe_allow), .first_timer_capture_in(cap),
      .compare_irq(irq), .wake_request(wake));
   task automatic stop_test();
      if (err_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one single word transfer; read data is taken at the data phase edge
   task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= htrans_nonseq;
      haddr <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask
   initial begin
      #200000;
      $display("[ERR] %0t watchdog expired", $time);
      err_count++;
      stop_test();
   end
   initial begin
      cyc(10);
      hresetn <= 1'b1;
      // unmapped write must leave every register at reset
      ahb(1'b1, 12'h00c, 32'hffff_ffff);
      for (int i = 0; i < 4; i++) begin
         ahb(1'b0, 12'(4 * i), 32'h0);
         chk(q, 32'h0);
      end
      lvl <= 1'b1;
      ahb(1'b0, status_ctrl_off, 32'h0);
      chk(q, 32'h0);
      ahb(1'b1, power_ctrl_off, 32'h1);
      ahb(1'b1, status_ctrl_off, en_c | ref_c);
      cyc(5);
      chk(32'({bbuf, bsel, ae}), 32'h7);
      ahb(1'b0, status_ctrl_off, 32'h0);
      chk(q & 32'hdf, en_c | ref_c | res_c);
      // every edge code, in run, shallow stop, wait and debug halt
      for (int m = 0; m < 4; m++) begin
         ctl = en_c | ie_c | pe_c | 32'(m);
         rise = m[0];
         wk = rise && m > 1;
         power_mode <= (m == 2) ? mode_shallow : (m == 3) ? mode_wait : mode_run;
         debug_halt <= m[0];
         lvl <= 1'b0;
         ahb(1'b1, status_ctrl_off, en_c);
         cyc(5);
         ahb(1'b1, status_ctrl_off, ctl | flg_c);
         cyc(2);
         chk(32'(irq), 32'h0);
         lvl <= 1'b1;
         cyc(5);
         chk(32'({irq, wake, opin, ooe}), 32'({rise, wk, 2'b11}));
         ahb(1'b1, status_ctrl_off, ctl);
         cyc(1);
         chk(32'(irq), 32'(rise));
         ahb(1'b1, status_ctrl_off, ctl | flg_c);
         cyc(1);
         chk(32'(irq), 32'h0);
         lvl <= 1'b0;
         cyc(5);
         chk(32'(irq), 32'(m != 1));
      end
      // still in wait: software turns the unneeded comparator off and clears the flag
      ahb(1'b1, status_ctrl_off, flg_c);
      cyc(1);
      chk(32'({ae, irq, wake}), 32'h0);
      power_mode <= mode_run;
      debug_halt <= 1'b0;
      ahb(1'b1, status_ctrl_off, en_c | ie_c | pe_c);
      ahb(1'b1, sys_options_off, 32'h1);
      lvl <= 1'b1;
      cyc(5);
      chk(32'({oe_allow, cap}), 32'h1);
      lvl <= 1'b0;
      cyc(5);
      chk(32'({oe_allow, cap}), 32'h0);
      ahb(1'b1, sys_options_off, 32'h0);
      cyc(1);
      chk(32'(oe_allow), 32'h1);
      power_mode <= mode_deep;
      cyc(3);
      chk(32'({ae, ooe, irq}), 32'h0);
      power_mode <= mode_run;
      ahb(1'b0, status_ctrl_off, 32'h0);
      chk(q, 32'h0);
      ahb(1'b1, status_ctrl_off, en_c | ie_c);
      ahb(1'b0, status_ctrl_off, 32'h0);
      chk(q & 32'hf7, en_c | ie_c);
      hresetn <= 1'b0;
      cyc(2);
      hresetn <= 1'b1;
      ahb(1'b0, status_ctrl_off, 32'h0);
      chk(q, 32'h0);
      ahb(1'b0, power_ctrl_off, 32'h0);
      chk(q, 32'h0);
      stop_test();
   end
endmodule
bind voltage_comparator_unit cmp_event_props u_props (.hclk, .hresetn, .hsel, .htrans,
   .hwrite, .hready, .hreadyout, .hresp, .power_mode, .raw_compare_out, .analog_enable,
   .compare_out_pin, .compare_out_pin_oe, .first_timer_chan0_pin_in,
   .first_timer_chan0_pin_oe_allow, .first_timer_capture_in, .compare_irq, .wake_request);
